// >>> ipb_pkg.sv
package ipb_pkg;
   localparam int PC_NREG = 7;
   localparam int PC_NSRC = 24;
   localparam int PC_AW = 8;
   localparam int PC_FW = 3;
   // Register byte offsets; index k holds priority_ctrl_(k+2)
   localparam logic [PC_AW-1:0] PC_OFF_CTRL_2 = 8'h00;
   localparam logic [PC_AW-1:0] PC_OFF_CTRL_3 = 8'h04;
   localparam logic [PC_AW-1:0] PC_OFF_CTRL_4 = 8'h08;
   localparam logic [PC_AW-1:0] PC_OFF_CTRL_5 = 8'h0c;
   localparam logic [PC_AW-1:0] PC_OFF_CTRL_6 = 8'h10;
   localparam logic [PC_AW-1:0] PC_OFF_CTRL_7 = 8'h14;
   localparam logic [PC_AW-1:0] PC_OFF_CTRL_8 = 8'h18;
   localparam logic [PC_AW-1:0] PC_OFF_LAST = PC_OFF_CTRL_8;
   // Implemented bits per register, index 0 = priority_ctrl_2
   localparam logic [PC_NREG-1:0][15:0] PC_IMPL_MASK = {
      16'h7777,
      16'h7777,
      16'h7777,
      16'h0007,
      16'h7777,
      16'h0777,
      16'h7777
   };
   localparam logic [15:0] PC_FIELD_RST = 16'h4444;
   localparam logic [1:0] PC_RESP_OKAY = 2'h0;
   localparam logic [1:0] PC_RESP_SLVERR = 2'h2;
   // Source index to register index and field shift
   localparam logic [2:0] PC_SRC_REG [PC_NSRC] = '{
      3'h0, 3'h0, 3'h0, 3'h0, 3'h1, 3'h1, 3'h1, 3'h2,
      3'h2, 3'h2, 3'h2, 3'h3, 3'h4, 3'h4, 3'h4, 3'h4,
      3'h5, 3'h5, 3'h5, 3'h5, 3'h6, 3'h6, 3'h6, 3'h6};
   localparam logic [3:0] PC_SRC_SHIFT [PC_NSRC] = '{
      4'h0, 4'h4, 4'h8, 4'hc, 4'h0, 4'h4, 4'h8, 4'h0,
      4'h4, 4'h8, 4'hc, 4'h0, 4'h0, 4'h4, 4'h8, 4'hc,
      4'h0, 4'h4, 4'h8, 4'hc, 4'h0, 4'h4, 4'h8, 4'hc};

   typedef logic [PC_FW-1:0] ipb_level_t;

   // Declared from source 23 down to source 0
   typedef struct packed {
      ipb_level_t crypto_rollover_priority;
      ipb_level_t crypto_buffer_free_priority;
      ipb_level_t spi2_tx_priority;
      ipb_level_t spi2_general_priority;
      ipb_level_t uart2_tx_priority;
      ipb_level_t uart2_rx_priority;
      ipb_level_t ext_irq2_priority;
      ipb_level_t timer5_priority;
      ipb_level_t timer4_priority;
      ipb_level_t out_compare4_priority;
      ipb_level_t out_compare3_priority;
      ipb_level_t dma_ch2_priority;
      ipb_level_t ext_irq1_priority;
      ipb_level_t change_notify_priority;
      ipb_level_t comparator_priority;
      ipb_level_t i2c1_master_priority;
      ipb_level_t i2c1_slave_priority;
      ipb_level_t dma_ch1_priority;
      ipb_level_t adc_priority;
      ipb_level_t uart1_tx_priority;
      ipb_level_t uart1_rx_priority;
      ipb_level_t spi1_tx_priority;
      ipb_level_t spi1_general_priority;
      ipb_level_t timer3_priority;
   } ipb_levels_t;

   typedef struct packed {
      logic [PC_NREG-1:0][15:0] prio;
      logic aw_held;
      logic [PC_AW-1:0] aw_addr;
      logic w_held;
      logic [15:0] w_data;
      logic [1:0] w_strb;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [15:0] rdata;
      logic [1:0] rresp;
      logic [PC_NSRC-1:0] pend;
   } ipb_state_t;
endpackage : ipb_pkg

// >>> ipb_bank.sv
`timescale 1ns/1ps
module ipb_bank
   import ipb_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [PC_AW-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [PC_AW-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [PC_NSRC-1:0] src_req,
   output ipb_levels_t src_levels,
   output logic [PC_NSRC-1:0] src_pending
);
   ipb_state_t st_reg;
   ipb_state_t st_next;
   logic [PC_NSRC-1:0][PC_FW-1:0] lvl;

   // Field value is the level itself: 111 is 7, 001 is 1
   genvar gi;
   generate
      for (gi = 0; gi < PC_NSRC; gi++) begin : g_src
         assign lvl[gi] = st_reg.prio[PC_SRC_REG[gi]][PC_SRC_SHIFT[gi] +: PC_FW];
      end
   endgenerate

   function automatic logic in_map(input logic [PC_AW-1:0] a);
      in_map = (a[1:0] == 2'h0) && (a <= PC_OFF_LAST);
   endfunction : in_map

   always_comb begin
      logic [2:0] widx;
      logic [2:0] ridx;
      logic [15:0] wmask;
      widx = st_reg.aw_addr[4:2];
      ridx = s_axi_araddr[4:2];
      wmask = {{8{st_reg.w_strb[1]}}, {8{st_reg.w_strb[0]}}};
      st_next = st_reg;
      if (s_axi_awvalid && st_reg.awready) begin
         st_next.aw_held = 1'b1;
         st_next.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && st_reg.wready) begin
         st_next.w_held = 1'b1;
         st_next.w_data = s_axi_wdata[15:0];
         st_next.w_strb = s_axi_wstrb[1:0];
      end
      if (s_axi_bvalid && s_axi_bready) begin
         st_next.bvalid = 1'b0;
      end
      // Commit one cycle after both halves are held
      if (st_reg.aw_held && st_reg.w_held && !st_reg.bvalid) begin
         st_next.aw_held = 1'b0;
         st_next.w_held = 1'b0;
         st_next.bvalid = 1'b1;
         st_next.bresp = PC_RESP_SLVERR;
         if (in_map(st_reg.aw_addr)) begin
            st_next.bresp = PC_RESP_OKAY;
            // Unimplemented bits never store state
            st_next.prio[widx] = ((st_reg.prio[widx] & ~wmask) | (st_reg.w_data & wmask))
               & PC_IMPL_MASK[widx];
         end
      end
      if (s_axi_rvalid && s_axi_rready) begin
         st_next.rvalid = 1'b0;
      end
      if (s_axi_arvalid && st_reg.arready) begin
         st_next.rvalid = 1'b1;
         st_next.rdata = 16'h0000;
         st_next.rresp = PC_RESP_SLVERR;
         if (in_map(s_axi_araddr)) begin
            st_next.rdata = st_reg.prio[ridx] & PC_IMPL_MASK[ridx];
            st_next.rresp = PC_RESP_OKAY;
         end
      end
      // Ready drops while a response waits, so at most one write is open
      st_next.awready = !st_next.aw_held && !st_next.bvalid;
      st_next.wready = !st_next.w_held && !st_next.bvalid;
      st_next.arready = !st_next.rvalid;
      for (int i = 0; i < PC_NSRC; i++) begin
         st_next.pend[i] = src_req[i] && (lvl[i] != 3'h0);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_reg <= '0;
         for (int k = 0; k < PC_NREG; k++) begin
            st_reg.prio[k] <= PC_FIELD_RST & PC_IMPL_MASK[k];
         end
      end else begin
         st_reg <= st_next;
      end
   end

   assign s_axi_awready = st_reg.awready;
   assign s_axi_wready = st_reg.wready;
   assign s_axi_bvalid = st_reg.bvalid;
   assign s_axi_bresp = st_reg.bresp;
   assign s_axi_arready = st_reg.arready;
   assign s_axi_rvalid = st_reg.rvalid;
   assign s_axi_rresp = st_reg.rresp;
   assign s_axi_rdata = {16'h0000, st_reg.rdata};
   assign src_levels = ipb_levels_t'(lvl);
   assign src_pending = st_reg.pend;
endmodule : ipb_bank

// >>> ipb_bank_properties.sv
`timescale 1ns/1ps
module ipb_bank_checker
   import ipb_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [PC_AW-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire ipb_levels_t src_levels,
   input wire logic [PC_NSRC-1:0] src_pending
);
   // Taken read address; its data stands in the next cycle
   wire [8:0] ar = {s_axi_arvalid && s_axi_arready, s_axi_araddr};
   default clocking @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   rst_level_a: assert property ($rose(aresetn) |-> src_levels.adc_priority == 3'h4)
      else $error("level after reset");
   off_quiet_a: assert property ($past(src_levels.timer3_priority) == 3'h0 |-> !src_pending[0])
      else $error("disabled pending");
   irq1_zero_a: assert property (ar == 9'h10c |=> s_axi_rdata[15:3] == 13'h0)
      else $error("reg 0c high bits");
   reg3_zero_a: assert property (ar == 9'h104 |=> (s_axi_rdata & 32'hf888) == 32'h0)
      else $error("reg 04 gaps");
   uart2_zero_a: assert property (ar == 9'h114 |=> (s_axi_rdata & 32'h8888) == 32'h0)
      else $error("reg 14 gaps");
   // Read data is the register as it stood at the take edge, so compare with the past level
   uart1_rx_a: assert property (ar == 9'h100 |=>
      s_axi_rdata[14:12] == $past(src_levels.uart1_rx_priority)) else $error("reg 00 field");
   notify_field_a: assert property (ar == 9'h108 |=>
      s_axi_rdata[14:12] == $past(src_levels.change_notify_priority)) else $error("reg 08 field");
   crypto_field_a: assert property (ar == 9'h118 |=>
      s_axi_rdata[10:8] == $past(src_levels.crypto_buffer_free_priority))
      else $error("reg 18 field");
   timer4_field_a: assert property (ar == 9'h110 |=>
      s_axi_rdata[14:12] == $past(src_levels.timer4_priority)) else $error("reg 10 field");
   dma1_field_a: assert property (ar == 9'h104 |=>
      s_axi_rdata[10:8] == $past(src_levels.dma_ch1_priority)) else $error("reg 04 field");
   irq1_field_a: assert property (ar == 9'h10c |=>
      s_axi_rdata[2:0] == $past(src_levels.ext_irq1_priority)) else $error("reg 0c field");
endmodule : ipb_bank_checker
bind ipb_bank ipb_bank_checker chk (.aclk, .aresetn, .s_axi_araddr, .s_axi_arvalid,
   .s_axi_arready, .s_axi_rdata, .src_levels, .src_pending);

// >>> test_interrupt_priority_bank.sv
`timescale 1ns/1ps
module test_interrupt_priority_bank;
   import ipb_pkg::*;
   logic aclk = 1'h0, aresetn = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
   logic s_axi_arvalid = 1'h0, s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic s_axi_arready, s_axi_rvalid;
   logic [PC_AW-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [31:0] s_axi_wdata = '0, s_axi_rdata;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [PC_NSRC-1:0] src_req = '1, src_pending;
   ipb_levels_t src_levels;
   int fails = 0, samples_checked = 0;
   logic [15:0] rst_val [7] = '{16'h4444, 16'h0444, 16'h4444, 16'h0004, 16'h4444, 16'h4444,
      16'h4444};
   // A distinct level in most fields and zero in two, to show disabled sources
   logic [15:0] pat [7] = '{16'h7531, 16'h0246, 16'h1357, 16'h0002, 16'h6420, 16'h3571,
      16'h2460};
   always #50 aclk = ~aclk;
   ipb_bank uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready(1'h1), .s_axi_araddr, .s_axi_arprot(3'h0),
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready(1'h1), .src_req, .src_levels, .src_pending);
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fails++;
         $display("Error %0t seen %h exp %h", $time, seen, exp);
      end
   endtask : check
   task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] er);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {16'h0, d};
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wready) s_axi_wvalid <= 1'h0;
      end while (!s_axi_bvalid);
      check({30'h0, s_axi_bresp}, {30'h0, er});
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [15:0] e, input logic [1:0] er);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'h0;
      do @(posedge aclk); while (!s_axi_rvalid);
      check(s_axi_rdata, {16'h0, e});
      check({30'h0, s_axi_rresp}, {30'h0, er});
   endtask : rd
   task finish_test;
      $display("checks %0d fails %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : finish_test
   initial begin
      repeat (6) @(posedge aclk);
      aresetn <= 1'h1;
      for (int i = 0; i < 7; i++) rd(8'(4 * i), rst_val[i], PC_RESP_OKAY);
      for (int i = 0; i < 7; i++) wr(8'(4 * i), 16'hffff, PC_RESP_OKAY);
      // Only implemented fields keep the ones
      for (int i = 0; i < 7; i++) begin
         rd(8'(4 * i), (rst_val[i] >> 2) * 16'h7, PC_RESP_OKAY);
      end
      // Reset again in mid-run: the written ones must be gone
      aresetn <= 1'h0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'h1;
      for (int i = 0; i < 7; i++) rd(8'(4 * i), rst_val[i], PC_RESP_OKAY);
      for (int i = 0; i < 7; i++) wr(8'(4 * i), pat[i], PC_RESP_OKAY);
      repeat (2) @(posedge aclk);
      check({8'h0, src_levels[71:48]}, 32'h00530779);
      check({8'h0, src_levels[47:24]}, 32'h00d1045d);
      check({8'h0, src_levels[23:0]}, 32'h00ea6f59);
      check({8'h0, src_pending}, 32'h00efefff);
      src_req <= 24'h00ff00;
      repeat (2) @(posedge aclk);
      check({8'h0, src_pending}, 32'h0000ef00);
      src_req <= '1;
      // Unmapped and misaligned writes must leave every register alone
      wr(8'h1c, 16'h0000, PC_RESP_SLVERR);
      wr(8'h02, 16'h0000, PC_RESP_SLVERR);
      rd(8'h00, pat[0], PC_RESP_OKAY);
      for (int c = 0; c < 8; c++) begin
         wr(8'h0, 16'(c), PC_RESP_OKAY);
         repeat (2) @(posedge aclk);
         check({29'h0, src_levels.timer3_priority}, 32'(c));
         check({31'h0, src_pending[0]}, 32'(c != 0));
      end
      rd(8'h1c, 16'h0, PC_RESP_SLVERR);
      finish_test();
   end
   // Tests need about 20 us, so ten times that means a hang
   initial begin
      #200000;
      fails++;
      finish_test();
   end
endmodule : test_interrupt_priority_bank
